/* File: psm_regs.vh */
// constants for the power saving mode controller
// assumes one system clock and an 8-bit plain register port
`ifndef PSM_REGS_VH
`define PSM_REGS_VH

`define PSM_ADDR_W        12
`define PSM_DATA_W        8
`define PSM_OFF_CTRL      12'h88c
`define PSM_OFF_STATUS    12'h890
`define PSM_OFF_OSCFORCE  12'h894

// control register fields
`define PSM_B_IDLE_SEL    7
`define PSM_B_SLOW_EN     6
`define PSM_B_RECOVER     5
`define PSM_B_RESUME_EXIT 4
`define PSM_F_RATIO_HI    2
`define PSM_F_RATIO_LO    0
`define PSM_CTRL_RST      8'h00
`define PSM_CTRL_MASK     8'hf7

// status register fields
`define PSM_B_TIMEOUT_N   4
`define PSM_B_PWRDOWN_N   3
`define PSM_F_MODE_HI     1
`define PSM_F_MODE_LO     0

// oscillator force register fields
`define PSM_B_HF_FORCE    2
`define PSM_B_LF_FORCE    1
`define PSM_B_SECONDARY_OSC_FORCE  0
`define PSM_OSCF_RST      8'h00

// modes
`define PSM_MODE_RUN      2'h0
`define PSM_MODE_IDLE     2'h1
`define PSM_MODE_SLEEP    2'h2
`define PSM_MODE_OST      2'h3

// start-up wait after a crystal wake, in oscillator periods
`define PSM_OST_PERIODS   11'h400
`define PSM_RATIO_W       3
`define PSM_CNT_W         8

`endif

/* File: psm_ctrl.v */
// power saving mode controller: slowdown, idle, sleep and wake-up
// assumes cpu, interrupt logic and watchdog are synchronous to i_clk
// and the oscillator period equals the system clock period
//
// Chosen here: the register addresses and the strobed register port.
`include "psm_regs.vh"

module psm_ctrl #(
    parameter PIN_N = 8
)(
    input  wire                   i_clk,
    input  wire                   i_nrst,
    input  wire [`PSM_ADDR_W-1:0] i_addr,
    input  wire [`PSM_DATA_W-1:0] i_wdata,
    input  wire                   i_wr,
    input  wire                   i_rd,
    output reg  [`PSM_DATA_W-1:0] o_rdata,
    input  wire                   i_sleep_exec,
    input  wire                   i_isr_enter,
    input  wire                   i_isr_return,
    input  wire                   i_prefetch_clears_gie,
    input  wire                   i_multicycle_busy,
    input  wire                   i_irq_pending,
    input  wire                   i_global_irq_enable,
    input  wire                   i_watchdog_wake,
    input  wire                   i_external_reset_pin,
    input  wire                   i_brownout_reset,
    input  wire                   i_por_reset,
    input  wire                   i_crystal_mode,
    input  wire                   i_lf_osc_request,
    input  wire                   i_hf_osc_request,
    input  wire                   i_secondary_osc_request,
    input  wire                   i_converter_on,
    input  wire                   i_converter_rc_clock,
    input  wire [PIN_N-1:0]       i_pin_periph_active,
    output reg                    o_cpu_cycle_en,
    output reg                    o_periph_clk_en,
    output reg                    o_bandgap_en,
    output reg                    o_sys_osc_en,
    output reg                    o_cpu_clk_en,
    output reg                    o_sys_clk_en,
    output reg                    o_low_freq_internal_osc_en,
    output reg                    o_high_freq_internal_osc_en,
    output reg                    o_secondary_osc_en,
    output reg                    o_converter_abort,
    output reg                    o_converter_powerdown,
    output reg  [PIN_N-1:0]       o_pin_hold,
    output reg                    o_vector_fetch,
    output reg                    o_prefetch_next,
    output reg                    o_watchdog_clear,
    output reg                    o_restart,
    output reg                    o_wake,
    output reg                    o_idle,
    output reg                    o_sleep
);

    reg [`PSM_DATA_W-1:0]  ctrl;
    reg [`PSM_DATA_W-1:0]  osc_force;
    reg                    powerdown_flag_n;
    reg                    timeout_flag_n;
    reg [1:0]              mode;
    reg [`PSM_CNT_W-1:0]   slow_cnt;
    reg [`PSM_RATIO_W-1:0] last_ratio;
    reg                    last_slow;
    reg [10:0]             ost_cnt;
    reg                    vector_after_wake;

    reg [`PSM_DATA_W-1:0]  next_ctrl;
    reg [1:0]              next_mode;
    reg                    next_pd_n;
    reg                    next_to_n;
    reg                    next_wdt_clear;
    reg                    next_wake;
    reg                    next_restart;
    reg                    next_abort;

    wire                   slow_cpu_enable = ctrl[`PSM_B_SLOW_EN];
    wire [`PSM_RATIO_W-1:0] ratio = ctrl[`PSM_F_RATIO_HI:`PSM_F_RATIO_LO];
    wire                   any_reset = i_external_reset_pin | i_brownout_reset | i_por_reset;
    wire                   ctrl_wr = i_wr && (i_addr == `PSM_OFF_CTRL);
    // decoded from next_mode so the enables switch on the same edge as o_sleep
    wire                   asleep = (next_mode == `PSM_MODE_SLEEP);
    wire                   stopped = asleep || (next_mode == `PSM_MODE_OST);

    function [`PSM_CNT_W-1:0] psm_last_count;
        input [`PSM_RATIO_W-1:0] code;
        begin
            // kept at counter width: code 7 wraps through zero to all ones
            psm_last_count = (({{(`PSM_CNT_W-1){1'b0}}, 1'b1} << code) << 1) -
                             {{(`PSM_CNT_W-1){1'b0}}, 1'b1};
        end
    endfunction

    // mode sequencing and control register updates
    always @*
    begin
        next_ctrl = ctrl;
        next_mode = mode;
        next_pd_n = powerdown_flag_n;
        next_to_n = timeout_flag_n;
        next_wdt_clear = 1'b0;
        next_wake = 1'b0;
        next_restart = 1'b0;
        next_abort = 1'b0;
        if (ctrl_wr)
        begin
            next_ctrl = i_wdata & `PSM_CTRL_MASK;
        end
        if (i_isr_enter)
        begin
            next_ctrl[`PSM_B_RESUME_EXIT] = ctrl[`PSM_B_SLOW_EN];
            if (ctrl[`PSM_B_RECOVER])
            begin
                next_ctrl[`PSM_B_SLOW_EN] = 1'b0;
            end
        end
        if (i_prefetch_clears_gie && ctrl[`PSM_B_RECOVER])
        begin
            next_ctrl[`PSM_B_SLOW_EN] = 1'b0;
        end
        if (i_isr_return)
        begin
            next_ctrl[`PSM_B_SLOW_EN] = ctrl[`PSM_B_RESUME_EXIT];
        end
        case (mode)
            `PSM_MODE_RUN:
            begin
                if (i_sleep_exec)
                begin
                    if (i_irq_pending && !i_global_irq_enable)
                    begin
                        next_mode = `PSM_MODE_RUN;
                    end
                    else if (ctrl[`PSM_B_IDLE_SEL])
                    begin
                        next_mode = `PSM_MODE_IDLE;
                    end
                    else
                    begin
                        next_mode = `PSM_MODE_SLEEP;
                        next_wdt_clear = 1'b1;
                        next_pd_n = 1'b0;
                        next_to_n = 1'b1;
                        next_abort = i_converter_on && !i_converter_rc_clock;
                    end
                end
            end
            `PSM_MODE_IDLE:
            begin
                if (i_irq_pending || i_watchdog_wake)
                begin
                    next_mode = `PSM_MODE_RUN;
                    next_wake = 1'b1;
                end
            end
            `PSM_MODE_SLEEP:
            begin
                if (i_irq_pending || i_watchdog_wake)
                begin
                    next_wdt_clear = 1'b1;
                    if (i_crystal_mode)
                    begin
                        next_mode = `PSM_MODE_OST;
                    end
                    else
                    begin
                        next_mode = `PSM_MODE_RUN;
                        next_wake = 1'b1;
                    end
                end
            end
            `PSM_MODE_OST:
            begin
                if (ost_cnt == `PSM_OST_PERIODS - 11'h001)
                begin
                    next_mode = `PSM_MODE_RUN;
                    next_wake = 1'b1;
                end
            end
            default:
            begin
                next_mode = `PSM_MODE_RUN;
            end
        endcase
        if (any_reset)
        begin
            next_mode = `PSM_MODE_RUN;
            next_restart = 1'b1;
            next_wake = 1'b0;
        end
    end

    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            ctrl <= `PSM_CTRL_RST;
            osc_force <= `PSM_OSCF_RST;
            powerdown_flag_n <= 1'b1;
            timeout_flag_n <= 1'b1;
            mode <= `PSM_MODE_RUN;
            ost_cnt <= 11'h000;
            slow_cnt <= {`PSM_CNT_W{1'b0}};
            last_ratio <= {`PSM_RATIO_W{1'b0}};
            last_slow <= 1'b0;
            vector_after_wake <= 1'b0;
            o_rdata <= 8'h00;
            o_cpu_cycle_en <= 1'b1;
            o_periph_clk_en <= 1'b1;
            o_bandgap_en <= 1'b1;
            o_sys_osc_en <= 1'b1;
            o_cpu_clk_en <= 1'b1;
            o_sys_clk_en <= 1'b1;
            o_low_freq_internal_osc_en <= 1'b1;
            o_high_freq_internal_osc_en <= 1'b1;
            o_secondary_osc_en <= 1'b0;
            o_converter_abort <= 1'b0;
            o_converter_powerdown <= 1'b0;
            o_pin_hold <= {PIN_N{1'b0}};
            o_vector_fetch <= 1'b0;
            o_prefetch_next <= 1'b0;
            o_watchdog_clear <= 1'b0;
            o_restart <= 1'b0;
            o_wake <= 1'b0;
            o_idle <= 1'b0;
            o_sleep <= 1'b0;
        end
        else
        begin
            ctrl <= next_ctrl;
            mode <= next_mode;
            powerdown_flag_n <= next_pd_n;
            timeout_flag_n <= next_to_n;
            if (i_wr && (i_addr == `PSM_OFF_OSCFORCE))
            begin
                osc_force <= i_wdata & 8'h07;
            end
            ost_cnt <= (mode == `PSM_MODE_OST) ? ost_cnt + 11'h001 : 11'h000;
            last_ratio <= ratio;
            last_slow <= slow_cpu_enable;
            // restart on enable or ratio change
            if ((slow_cpu_enable && !last_slow) || (ratio != last_ratio) ||
                (slow_cnt >= psm_last_count(ratio)))
            begin
                slow_cnt <= {`PSM_CNT_W{1'b0}};
            end
            else
            begin
                slow_cnt <= slow_cnt + {{(`PSM_CNT_W-1){1'b0}}, 1'b1};
            end
            o_cpu_cycle_en <= (mode == `PSM_MODE_RUN) && (!next_ctrl[`PSM_B_SLOW_EN] ||
                (slow_cpu_enable && !last_slow) || (ratio != last_ratio) ||
                (slow_cnt >= psm_last_count(ratio)));
            o_periph_clk_en <= !stopped;
            o_bandgap_en <= 1'b1;
            o_sys_osc_en <= !stopped;
            o_cpu_clk_en <= (next_mode == `PSM_MODE_RUN);
            o_sys_clk_en <= !(next_mode == `PSM_MODE_SLEEP || next_mode == `PSM_MODE_OST);
            o_low_freq_internal_osc_en <= !asleep || i_lf_osc_request ||
                osc_force[`PSM_B_LF_FORCE];
            o_high_freq_internal_osc_en <= !asleep || i_hf_osc_request ||
                osc_force[`PSM_B_HF_FORCE];
            o_secondary_osc_en <= i_secondary_osc_request || osc_force[`PSM_B_SECONDARY_OSC_FORCE];
            o_converter_abort <= next_abort;
            o_converter_powerdown <= (next_mode == `PSM_MODE_SLEEP) && i_converter_on &&
                !i_converter_rc_clock;
            // pin hold only when idle peripheral
            o_pin_hold <= (next_mode == `PSM_MODE_SLEEP) ? ~i_pin_periph_active
                                                         : {PIN_N{1'b0}};
            o_prefetch_next <= i_sleep_exec && (mode == `PSM_MODE_RUN);
            o_watchdog_clear <= next_wdt_clear;
            o_restart <= next_restart;
            o_wake <= next_wake;
            o_idle <= (next_mode == `PSM_MODE_IDLE);
            o_sleep <= (next_mode == `PSM_MODE_SLEEP) || (next_mode == `PSM_MODE_OST);
            if (next_wake && i_global_irq_enable)
            begin
                vector_after_wake <= 1'b1;
            end
            else if (o_vector_fetch || any_reset)
            begin
                vector_after_wake <= 1'b0;
            end
            o_vector_fetch <= (mode == `PSM_MODE_RUN) && !any_reset && !o_vector_fetch &&
                i_irq_pending && i_global_irq_enable && !i_multicycle_busy &&
                !o_wake && !i_sleep_exec;
            if (i_rd)
            begin
                case (i_addr)
                    `PSM_OFF_CTRL:
                    begin
                        o_rdata <= ctrl;
                    end
                    `PSM_OFF_STATUS:
                    begin
                        o_rdata <= {3'h0, timeout_flag_n, powerdown_flag_n,
                                    vector_after_wake, mode};
                    end
                    `PSM_OFF_OSCFORCE:
                    begin
                        o_rdata <= osc_force;
                    end
                    default:
                    begin
                        o_rdata <= 8'h00;
                    end
                endcase
            end
            else
            begin
                o_rdata <= 8'h00;
            end
        end
    end

endmodule

/* File: psm_ctrl_properties.sv */
// concurrent checks on the power saving controller ports
// assumes one clock domain and the async active-low reset of the block
module psm_ctrl_properties #(
    parameter PIN_N = 8
)(
    input logic             i_clk,
    input logic             i_nrst,
    input logic             i_sleep_exec,
    input logic             i_irq_pending,
    input logic             i_global_irq_enable,
    input logic             i_crystal_mode,
    input logic             i_secondary_osc_request,
    input logic             i_converter_on,
    input logic             i_converter_rc_clock,
    input logic             o_periph_clk_en,
    input logic             o_bandgap_en,
    input logic             o_cpu_clk_en,
    input logic             o_sys_clk_en,
    input logic             o_secondary_osc_en,
    input logic             o_converter_abort,
    input logic [PIN_N-1:0] o_pin_hold,
    input logic             o_prefetch_next,
    input logic             o_watchdog_clear,
    input logic             o_wake,
    input logic             o_idle,
    input logic             o_sleep
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);

    sequence s_sleep_req;
        i_sleep_exec && !o_sleep && !o_idle;
    endsequence
    sequence s_sleep_nop;
        s_sleep_req ##0 (i_irq_pending && !i_global_irq_enable);
    endsequence

    a_bandgap_stays_on: assert property (o_bandgap_en)
        else $error("bandgap enable dropped");
    a_periph_full_rate: assert property (!o_sleep |-> o_periph_clk_en)
        else $error("peripheral clock stopped outside sleep");
    a_sleep_clocks_off: assert property (o_sleep |-> !o_cpu_clk_en && !o_sys_clk_en)
        else $error("cpu or system clock running in sleep");
    a_idle_cpu_halt: assert property (o_idle |-> !o_cpu_clk_en && o_periph_clk_en && !o_sleep)
        else $error("idle clocks wrong");
    a_prefetch_next_pc: assert property (s_sleep_req |=> o_prefetch_next)
        else $error("no prefetch after sleep instruction");
    a_sleep_as_nop: assert property (s_sleep_nop |=> !o_sleep && !o_idle && !o_watchdog_clear)
        else $error("pending interrupt did not make sleep a no-op");
    a_entry_clears_wdt: assert property ($rose(o_sleep) |-> o_watchdog_clear)
        else $error("watchdog not cleared at sleep entry");
    a_wake_clears_wdt: assert property (o_wake && $past(o_sleep) && !i_crystal_mode |-> o_watchdog_clear)
        else $error("watchdog not cleared at wake");
    a_secondary_osc_request_on: assert property (i_secondary_osc_request |=> o_secondary_osc_en)
        else $error("requested secondary oscillator off");
    a_hold_only_sleep: assert property ((o_pin_hold != 0) |-> o_sleep)
        else $error("pin hold outside sleep");
    a_converter_abort: assert property (s_sleep_req ##1 $rose(o_sleep)
        |-> o_converter_abort == ($past(i_converter_on) && !$past(i_converter_rc_clock)))
        else $error("converter abort wrong at sleep entry");
endmodule

bind psm_ctrl psm_ctrl_properties #(.PIN_N(PIN_N)) u_props (.*);

/* File: psm_cpu_model.sv */
// cpu core, interrupt logic and watchdog as seen by the controller
// assumes the bench calls its tasks between clock edges in sequence
module psm_cpu_model (
    input  logic i_clk,
    input  logic i_wake,
    output logic o_sleep_exec,
    output logic o_isr_enter,
    output logic o_isr_return,
    output logic o_watchdog_wake,
    output logic o_irq_pending
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] ev = 4'h0;
    assign {o_watchdog_wake, o_isr_return, o_isr_enter, o_sleep_exec} = ev;
    initial o_irq_pending = 1'b0;
    // flag is cleared on the clock edge that sees the wake pulse
    always @(posedge i_clk)
        if (i_wake)
            o_irq_pending <= 1'b0;
    task automatic pulse(input logic [3:0] m);
        @(posedge i_clk);
        ev <= m;
        @(posedge i_clk);
        ev <= 4'h0;
    endtask
    task automatic set_irq(input logic v);
        @(posedge i_clk);
        o_irq_pending <= v;
    endtask
endmodule

/* File: test_power_saving_mode_control.sv */
// self-checking bench for the power saving mode controller
// assumes register offsets and status layout from psm_regs.vh
`include "psm_regs.vh"
module test_power_saving_mode_control;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clk = 0, i_nrst = 0, i_wr = 0, i_rd = 0, i_prefetch_clears_gie = 0;
    logic [11:0] i_addr = 0;
    logic [7:0]  i_wdata = 0, i_pin_periph_active = 0, o_rdata, o_pin_hold;
    logic i_multicycle_busy = 0, i_global_irq_enable = 0, i_external_reset_pin = 0;
    logic i_brownout_reset = 0, i_por_reset = 0, i_crystal_mode = 0;
    logic i_lf_osc_request = 0, i_hf_osc_request = 0, i_secondary_osc_request = 0;
    logic i_converter_on = 0, i_converter_rc_clock = 0;
    logic i_sleep_exec, i_isr_enter, i_isr_return, i_irq_pending, i_watchdog_wake;
    logic o_cpu_cycle_en, o_periph_clk_en, o_bandgap_en, o_sys_osc_en, o_cpu_clk_en;
    logic o_sys_clk_en, o_low_freq_internal_osc_en, o_high_freq_internal_osc_en;
    logic o_secondary_osc_en, o_converter_abort, o_converter_powerdown, o_vector_fetch;
    logic o_prefetch_next, o_watchdog_clear, o_restart, o_wake, o_idle, o_sleep;
    int bad_count = 0, compares = 0, n;
    logic [7:0] d;

    psm_ctrl u_dut (.*);
    psm_cpu_model u_cpu (.i_clk(i_clk), .i_wake(o_wake), .o_sleep_exec(i_sleep_exec),
        .o_isr_enter(i_isr_enter), .o_isr_return(i_isr_return),
        .o_watchdog_wake(i_watchdog_wake), .o_irq_pending(i_irq_pending));

    initial forever #2.5 i_clk = ~i_clk;

    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [7:0] v);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask
    // bounded wait, one edge at a time, for the wake pulse
    task automatic wait_wake(input int lim);
        #1;
        for (n = 0; n < lim && o_wake !== 1'b1; n++)
            @(posedge i_clk) #1;
    endtask
    task automatic t_regs;
        rd(`PSM_OFF_STATUS, d);
        chk("status reset", d, 8'h18);
        wr(`PSM_OFF_CTRL, 8'hff);
        rd(`PSM_OFF_CTRL, d);
        chk("ctrl mask", d, 8'hf7);
        wr(`PSM_OFF_OSCFORCE, 8'hff);
        rd(`PSM_OFF_OSCFORCE, d);
        chk("osc force", d, 8'h07);
        wr(`PSM_OFF_OSCFORCE, 8'h00);
        wr(`PSM_OFF_CTRL, 8'h00);
        rd(12'h123, d);
        chk("unmapped", d, 8'h00);
        $display("t_regs done");
    endtask
    task automatic t_nop;
        u_cpu.set_irq(1'b1);
        u_cpu.pulse(4'h1);
        repeat (2) @(posedge i_clk);
        #1 chk("nop sleep", o_sleep, 0);
        rd(`PSM_OFF_STATUS, d);
        chk("nop flags", d, 8'h18);
        u_cpu.set_irq(1'b0);
        $display("t_nop done");
    endtask
    task automatic t_slow;
        for (int k = 0; k < 5; k++)
        begin
            wr(`PSM_OFF_CTRL, 8'h40 | k);
            repeat (3) @(posedge i_clk);
            n = 0;
            repeat (4 << k)
            begin
                @(posedge i_clk) #1;
                n += o_cpu_cycle_en;
                chk("periph rate", o_periph_clk_en && o_sys_osc_en, 1);
            end
            // two cpu cycles in two ratio windows
            chk("slow ratio", n, 2);
        end
        $display("t_slow done");
    endtask
    task automatic t_isr;
        wr(`PSM_OFF_CTRL, 8'h60);
        u_cpu.pulse(4'h2);
        rd(`PSM_OFF_CTRL, d);
        chk("isr recover", d, 8'h30);
        u_cpu.pulse(4'h4);
        rd(`PSM_OFF_CTRL, d);
        chk("return resume", d, 8'h70);
        wr(`PSM_OFF_CTRL, 8'h40);
        u_cpu.pulse(4'h2);
        rd(`PSM_OFF_CTRL, d);
        chk("isr keep", d, 8'h50);
        wr(`PSM_OFF_CTRL, 8'h40);
        u_cpu.pulse(4'h4);
        rd(`PSM_OFF_CTRL, d);
        chk("return normal", d, 8'h00);
        wr(`PSM_OFF_CTRL, 8'h60);
        @(posedge i_clk) i_prefetch_clears_gie <= 1'b1;
        @(posedge i_clk) i_prefetch_clears_gie <= 1'b0;
        rd(`PSM_OFF_CTRL, d);
        chk("prefetch gie", d[6], 0);
        wr(`PSM_OFF_CTRL, 8'h00);
        $display("t_isr done");
    endtask
    task automatic t_sleep;
        i_converter_on <= 1'b1;
        i_pin_periph_active <= 8'h0f;
        i_secondary_osc_request <= 1'b1;
        i_lf_osc_request <= 1'b1;
        u_cpu.pulse(4'h1);
        #1 chk("in sleep", {o_sleep, o_cpu_clk_en, o_converter_powerdown}, 3'b101);
        chk("pin hold", o_pin_hold, 8'hf0);
        rd(`PSM_OFF_STATUS, d);
        chk("sleep flags", d, 8'h12);
        chk("lf osc kept", o_low_freq_internal_osc_en, 1);
        chk("hf osc off", o_high_freq_internal_osc_en, 0);
        u_cpu.set_irq(1'b1);
        wait_wake(20);
        chk("irq wake", {o_wake, o_watchdog_clear, o_sleep}, 3'b110);
        wr(`PSM_OFF_CTRL, 8'h80);
        u_cpu.pulse(4'h1);
        #1 chk("idle", {o_idle, o_sleep}, 2'b10);
        u_cpu.pulse(4'h8);
        wait_wake(20);
        chk("idle wake", o_wake, 1);
        wr(`PSM_OFF_CTRL, 8'h00);
        $display("t_sleep done");
    endtask
    task automatic t_xtal;
        i_crystal_mode <= 1'b1;
        i_global_irq_enable <= 1'b1;
        i_multicycle_busy <= 1'b1;
        i_converter_rc_clock <= 1'b1;
        i_lf_osc_request <= 1'b0;
        i_hf_osc_request <= 1'b1;
        u_cpu.pulse(4'h1);
        #1 chk("rc clock kept", o_converter_powerdown, 0);
        chk("hf osc kept", o_high_freq_internal_osc_en, 1);
        chk("lf osc off", o_low_freq_internal_osc_en, 0);
        u_cpu.set_irq(1'b1);
        wait_wake(1100);
        chk("ost length", n >= 1020 && n <= 1030, 1);
        rd(`PSM_OFF_STATUS, d);
        chk("vector pending", d[2], 1);
        u_cpu.set_irq(1'b1);
        repeat (2) @(posedge i_clk);
        #1 chk("busy holds vector", o_vector_fetch, 0);
        @(posedge i_clk) i_multicycle_busy <= 1'b0;
        @(posedge i_clk) #1 chk("vector fetch", o_vector_fetch, 1);
        u_cpu.set_irq(1'b0);
        i_crystal_mode <= 1'b0;
        // each reset source in turn must restart
        for (int r = 0; r < 3; r++)
        begin
            @(posedge i_clk) {i_por_reset, i_brownout_reset, i_external_reset_pin} <= 3'b001 << r;
            @(posedge i_clk) {i_por_reset, i_brownout_reset, i_external_reset_pin} <= 3'h0;
            #1 chk("restart", o_restart, 1);
        end
        $display("t_xtal done");
    endtask
    task automatic final_report;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        repeat (6) @(posedge i_clk);
        i_nrst <= 1'b1;
        t_regs();
        t_nop();
        t_slow();
        t_isr();
        t_sleep();
        t_xtal();
        final_report();
    end
    initial
    begin
        repeat (20000) @(posedge i_clk);
        bad_count++;
        final_report();
    end
endmodule
